// *** dv/sgf_pe_model.sv ***
// processing element model: classic wishbone master
`timescale 1ns/10ps
module sgf_pe_model (
	input  wire logic        sys_clk,
	input  wire logic        ack,
	input  wire logic        err,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic      [17:0] adr,
	output logic      [3:0]  sel,
	output logic      [31:0] dat,
	output logic             sec,
	output logic      [1:0]  pe,
	output logic             hung
);
	initial begin
		{cyc, stb, we, sec, hung} = '0;
		{adr, sel, dat, pe} = '1;
	end
	task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic sc, input logic [1:0] p);
		int n;
		n = 0;
		@(posedge sys_clk);
		{cyc, stb, we, adr, dat, sel, sec, pe} <= {2'b11, w, a, d, s, sc, p};
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
		if (n >= 40)
			hung <= 1'b1;
		// released address and data lines show inverted values; we, sel, sec and pe keep the old ones
		{cyc, stb, adr, dat} <= {2'b00, ~a, ~d};
	endtask
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the swint forwarding block
`timescale 1ns/10ps
module tb_top;
	import sgf_pkg::*;
	typedef struct {logic rd; logic er; logic [31:0] dt; logic [3:0] fi; logic [3:0] g0; logic [3:0] id;} sgf_exp_s;
	logic        sys_clk = 0;
	logic        rst_n = 0;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_secure_i, wb_ack_o, wb_err_o, hung;
	logic [17:0] wb_adr_i;
	logic [3:0]  wb_sel_i, swint_fire, swint_group0, swint_id, nsac;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [1:0]  wb_pe_i;
	logic [3:0]  ctl = 0;
	logic [7:0]  grp = 0;
	logic [7:0]  nsv;
	logic [3:0]  lastf = 0;
	sgf_exp_s    q[$];
	sgf_exp_s    me;
	int          num_errors = 0;
	int          cmp_count = 0;
	always #2 sys_clk = ~sys_clk;
	sgf_top sgf_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_secure_i(wb_secure_i), .wb_pe_i(wb_pe_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o), .swint_fire(swint_fire), .swint_group0(swint_group0), .swint_id(swint_id));
	sgf_pe_model sgf_pe_model_i (.sys_clk(sys_clk), .ack(wb_ack_o), .err(wb_err_o), .cyc(wb_cyc_i),
		.stb(wb_stb_i), .we(wb_we_i), .adr(wb_adr_i), .sel(wb_sel_i), .dat(wb_dat_i),
		.sec(wb_secure_i), .pe(wb_pe_i), .hung(hung));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (e !== s) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic report_and_stop;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	function automatic logic dec(input int k, input logic s, input logic [1:0] g, input logic n, input logic ds);
		if (s)
			return k == 0 ? (g == 1 || (g == 0 && ds)) : k == 1 ? g == 2 : g == 0;
		return k == 0 ? (g == 2 || (g == 1 && n) || (g == 0 && (n || ds))) :
			k == 1 ? ((g == 1 && n) || (g == 0 && (n || ds))) : (g == 0 && (n || ds));
	endfunction
	task automatic acc(input logic w, input logic [17:0] a, input logic [31:0] d, input logic s, input logic er,
			input logic [31:0] ex, input logic [3:0] sl = 4'hF, input logic [1:0] p = 2'h0);
		q.push_back('{!w, er, ex, 4'h0, 4'h0, 4'h0});
		sgf_pe_model_i.xfer(w, a, d, sl, s, p);
	endtask
	task automatic gen(input int k, input logic s, input logic [3:0] t, input logic [3:0] id);
		sgf_exp_s e;
		e = '{1'b0, 1'b0, 32'h0, 4'h0, 4'h0, id};
		for (int i = 0; i < 4; i++)
			if (t[i] && ctl[1] && ctl[2] && dec(k, s, grp[2*i+:2], nsac[i], ctl[0])) begin
				e.fi[i] = 1'b1;
				e.g0[i] = grp[2*i+:2] == 0 || (grp[2*i+:2] == 1 && (!ctl[3] || ctl[0]));
			end
		lastf = e.fi;
		q.push_back(e);
		sgf_pe_model_i.xfer(1'b1, 18'h10010 + 18'(4 * k), {20'h0, id, t, 4'h0}, 4'hF, s, 2'h0);
	endtask
	always @(posedge sys_clk)
		if (rst_n && (wb_ack_o === 1'b1 || wb_err_o === 1'b1)) begin
			me = q.pop_front();
			chk("err", me.er, wb_err_o);
			if (me.er) begin
			end else if (me.rd)
				chk("rdata", me.dt, wb_dat_o);
			else begin
				chk("fire", me.fi, swint_fire);
				chk("group0", me.g0, swint_group0);
				if (me.fi != 0)
					chk("id", me.id, swint_id);
			end
		end
	always @(posedge hung) begin
		num_errors++;
		report_and_stop();
	end
	initial begin
		void'($urandom(24));
		nsac = 0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		gen(0, 1, 4'hF, 4'h5);
		for (int f = 0; f < 3; f++) begin
			acc(0, 18'(f << 16) | 18'hFFE8, 0, 0, 0, {24'h0, SGF_REV_VALUE, 4'h0});
			acc(1, 18'(f << 16) | 18'hFFE8, 32'hFFFF_FFFF, 1, 0, 0);
			acc(0, 18'(f << 16) | 18'hFFE8, 0, 1, 0, {24'h0, SGF_REV_VALUE, 4'h0});
			acc(0, 18'(f << 16) | 18'hFFD0, 0, 1, 0, SGF_IMPDEF_VALUE);
		end
		acc(0, 18'h30000, 0, 1, 1, 0);
		acc(0, 18'h00100, 0, 1, 1, 0);
		acc(1, 18'h00000, 32'hF, 0, 0, 0);
		acc(0, 18'h00000, 0, 1, 0, 0);
		acc(1, 18'h00000, 32'hF, 1, 0, 0, 4'h3);
		acc(0, 18'h00000, 0, 1, 0, 0);
		acc(1, 18'h00020, 32'hA5A5_0001, 1, 0, 0);
		acc(1, 18'h00020, 32'h5A5A_0002, 0, 0, 0);
		acc(1, 18'h00020, 32'h0F0F_0003, 1, 0, 0, 4'hF, 2'h1);
		acc(0, 18'h00020, 0, 1, 0, 32'hA5A5_0001);
		acc(0, 18'h00020, 0, 0, 0, 32'h5A5A_0002);
		acc(0, 18'h00020, 0, 1, 0, 32'h0F0F_0003, 4'hF, 2'h1);
		for (int m = 0; m < 4; m++) begin
			ctl = {m[1], 2'b11, m[0]};
			acc(1, 18'h00000, {28'h0, ctl}, 1, 0, 0);
			repeat (5) begin
				for (int i = 0; i < 4; i++)
					grp[2*i+:2] = 2'($urandom_range(0, 2));
				nsac = 4'($urandom);
				acc(1, 18'h10004, {24'h0, grp}, 1, 0, 0);
				acc(1, 18'h10008, {28'h0, nsac}, 1, 0, 0);
				acc(0, 18'h10008, 0, 0, 0, 0);
				if (!ctl[0]) begin
					for (int i = 0; i < 4; i++)
						nsv[2*i+:2] = grp[2*i+:2] == 2 ? 2'h2 : 2'h0;
					acc(1, 18'h10004, 32'hAA, 0, 0, 0);
					acc(0, 18'h10004, 0, 0, 0, {24'h0, nsv});
				end
				for (int k = 0; k < 3; k++)
					for (int s = 0; s < 2; s++)
						gen(k, s[0], 4'($urandom), 4'($urandom));
				acc(0, 18'h00030, 0, 1, 0, {28'h0, lastf});
				acc(1, 18'h1001C, 32'h0000_05F0, m[0], 0, 0);
			end
		end
		repeat (4) @(posedge sys_clk);
		chk("pending", 0, q.size());
		report_and_stop();
	end
endmodule

// *** rtl/sgf_bank.sv ***
// security-banked word, one copy per security state
`timescale 1ns/10ps
module sgf_bank
	import sgf_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         wr,
	input  wire logic         secure,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] rdata
);
	typedef struct packed {
		logic [W-1:0] s_copy;
		logic [W-1:0] ns_copy;
	} sgf_bank_s;
	sgf_bank_s st_reg;
	sgf_bank_s st_next;

	always_comb begin
		st_next = st_reg;
		if (wr && secure)
			st_next.s_copy = wdata;
		if (wr && !secure)
			st_next.ns_copy = wdata;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign rdata = secure ? st_reg.s_copy : st_reg.ns_copy;
endmodule

// *** rtl/sgf_decide.sv ***
// per-target forwarding decision for a software-generated interrupt
`timescale 1ns/10ps
module sgf_decide
	import sgf_pkg::*;
(
	sgf_fwd_if.dec                      fwd,
	input  wire logic [2*SGF_NPE-1:0]   grp_cfg,
	input  wire logic [SGF_NPE-1:0]     nsac_ok,
	input  wire logic                   ds,
	input  wire logic                   sre_s,
	input  wire logic                   ar_both
);
	function automatic logic allow(sgf_gen_e k, logic sec, sgf_grp_e g, logic nsok, logic dsb);
		logic r;
		r = 1'b0;
		if (sec) begin
			unique case (k)
				SGF_GEN_G1:     r = (g == SGF_GRP_S1) || (g == SGF_GRP_S0 && dsb);
				SGF_GEN_ALT_G1: r = (g == SGF_GRP_NS1);
				SGF_GEN_G0:     r = (g == SGF_GRP_S0);
				default:        r = 1'b0;
			endcase
		end else begin
			unique case (k)
				SGF_GEN_G1:     r = (g == SGF_GRP_NS1) || (g == SGF_GRP_S1 && nsok);
				SGF_GEN_ALT_G1: r = (g == SGF_GRP_S1 && nsok);
				SGF_GEN_G0:     r = 1'b0;
				default:        r = 1'b0;
			endcase
			if (k != SGF_GEN_NONE && g == SGF_GRP_S0 && (nsok || dsb))
				r = 1'b1;
		end
		return r;
	endfunction

	always_comb begin
		for (int i = 0; i < SGF_NPE; i++) begin
			// any delivery only with routing on for both states
			fwd.signal[i] = fwd.valid && fwd.targets[i] && ar_both &&
				allow(fwd.kind, fwd.secure, sgf_grp_e'(grp_cfg[2*i +: 2]), nsac_ok[i], ds);
			// secure group 0 always goes out as group 0, secure group 1 only when demoted
			fwd.as_group0[i] = (sgf_grp_e'(grp_cfg[2*i +: 2]) == SGF_GRP_S0) ||
				((sgf_grp_e'(grp_cfg[2*i +: 2]) == SGF_GRP_S1) && (!sre_s || ds));
		end
	end
endmodule

// *** rtl/sgf_fwd_if.sv ***
// interface: one generate request from the bus slave to the forwarding decision
`timescale 1ns/10ps
interface sgf_fwd_if;
	import sgf_pkg::*;
	logic               valid;
	sgf_gen_e           kind;
	logic               secure;
	logic [SGF_NPE-1:0] targets;
	logic [3:0]         intid;
	logic [SGF_NPE-1:0] signal;
	logic [SGF_NPE-1:0] as_group0;
	modport req (output valid, kind, secure, targets, intid, input signal, as_group0);
	modport dec (input valid, kind, secure, targets, intid, output signal, as_group0);
endinterface

// *** rtl/sgf_pkg.sv ***
// package: offsets, fields, reset values and types for the swint forwarding block
package sgf_pkg;
	localparam int          SGF_AW            = 18;
	localparam int          SGF_NPE           = 4;
	localparam int          SGF_PE_W          = 2;
	// register map, three 64 KB frames
	localparam logic [17:0] SGF_FRAME_DIST    = 18'h00000;
	localparam logic [17:0] SGF_FRAME_REDIST  = 18'h10000;
	localparam logic [17:0] SGF_FRAME_TRANS   = 18'h20000;
	localparam logic [15:0] SGF_ID_LO         = 16'hFFD0;
	localparam logic [15:0] SGF_ID_HI         = 16'hFFFC;
	localparam logic [15:0] SGF_ARCH_REV_OFS  = 16'hFFE8;
	localparam logic [15:0] SGF_CTRL_OFS      = 16'h0000;
	localparam logic [15:0] SGF_GROUP_OFS     = 16'h0004;
	localparam logic [15:0] SGF_NSAC_OFS      = 16'h0008;
	localparam logic [15:0] SGF_GEN_OFS       = 16'h0010;
	localparam logic [15:0] SGF_BANK_OFS      = 16'h0020;
	localparam logic [15:0] SGF_STATUS_OFS    = 16'h0030;
	// control register fields
	localparam int          SGF_CTRL_DS_BIT   = 0;
	localparam int          SGF_CTRL_AR_S_BIT = 1;
	localparam int          SGF_CTRL_AR_NS_BIT = 2;
	localparam int          SGF_CTRL_SRE_S_BIT = 3;
	// generate register fields
	localparam int          SGF_GEN_KIND_LSB  = 0;
	localparam int          SGF_GEN_TGT_LSB   = 4;
	localparam int          SGF_GEN_ID_LSB    = 8;
	// revision field
	localparam int          SGF_REV_LSB       = 4;
	localparam logic [3:0]  SGF_REV_VALUE     = 4'h3;
	localparam logic [31:0] SGF_IMPDEF_VALUE  = 32'h0000_0000;
	localparam logic [3:0]  SGF_CTRL_RESET    = 4'h0;
	localparam logic [31:0] SGF_BANK_RESET    = 32'h0000_0000;

	typedef enum logic [1:0] {SGF_GEN_G1, SGF_GEN_ALT_G1, SGF_GEN_G0, SGF_GEN_NONE} sgf_gen_e;
	typedef enum logic [1:0] {SGF_GRP_S0, SGF_GRP_S1, SGF_GRP_NS1} sgf_grp_e;
endpackage

// *** rtl/sgf_top.sv ***
// top: wishbone slave, per-element state and swint forwarding
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
module sgf_top
	import sgf_pkg::*;
#(
	parameter logic [3:0] REV = SGF_REV_VALUE
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [SGF_AW-1:0]    wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	input  wire logic                 wb_secure_i,
	input  wire logic [SGF_PE_W-1:0]  wb_pe_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	output logic                      wb_err_o,
	output logic      [SGF_NPE-1:0]   swint_fire,
	output logic      [SGF_NPE-1:0]   swint_group0,
	output logic      [3:0]           swint_id
);
	typedef struct packed {
		logic [3:0]           ctrl;
		logic [2*SGF_NPE-1:0] grp;
		logic [SGF_NPE-1:0]   nsac;
		logic [31:0]          rdata;
		logic                 ack;
		logic                 err;
		logic [SGF_NPE-1:0]   fire;
		logic [SGF_NPE-1:0]   g0;
		logic [3:0]           id;
		logic [SGF_NPE-1:0]   last_fire;
	} sgf_top_s;
	sgf_top_s st_reg;
	sgf_top_s st_next;

	sgf_fwd_if fwd ();
	logic [SGF_NPE-1:0] bank_wr;
	logic [31:0]        bank_rd [SGF_NPE];

	// an error answer also ends the request, else a held strobe errs twice
	wire         req    = wb_cyc_i && wb_stb_i && !st_reg.ack && !st_reg.err;
	wire [1:0]   frame  = wb_adr_i[17:16];
	wire [15:0]  ofs    = {wb_adr_i[15:2], 2'b00};
	wire         full_w = (wb_sel_i == 4'hF);
	wire         in_id  = (ofs >= SGF_ID_LO) && (ofs <= SGF_ID_HI);
	wire         known  = (frame != 2'b11);
	wire         wr_ok  = req && wb_we_i && full_w && known;

	function automatic logic is_reg(logic [15:0] o, logic [15:0] r, logic [1:0] f, logic [1:0] want);
		return (o == r) && (f == want);
	endfunction

	wire hit_ctrl = is_reg(ofs, SGF_CTRL_OFS, frame, SGF_FRAME_DIST[17:16]);
	wire hit_grp  = is_reg(ofs, SGF_GROUP_OFS, frame, SGF_FRAME_REDIST[17:16]);
	wire hit_nsac = is_reg(ofs, SGF_NSAC_OFS, frame, SGF_FRAME_REDIST[17:16]);
	wire hit_gen  = (ofs[15:4] == SGF_GEN_OFS[15:4]) && (frame == SGF_FRAME_REDIST[17:16]);
	wire hit_bank = is_reg(ofs, SGF_BANK_OFS, frame, SGF_FRAME_DIST[17:16]);
	wire hit_stat = is_reg(ofs, SGF_STATUS_OFS, frame, SGF_FRAME_DIST[17:16]);
	wire hit_any  = in_id || hit_ctrl || hit_grp || hit_nsac || hit_gen || hit_bank || hit_stat;

	// generate request: low address bits pick the register kind
	assign fwd.valid   = wr_ok && hit_gen;
	assign fwd.kind    = sgf_gen_e'(ofs[3:2]);
	assign fwd.secure  = wb_secure_i;
	assign fwd.targets = wb_dat_i[SGF_GEN_TGT_LSB +: SGF_NPE];
	assign fwd.intid   = wb_dat_i[SGF_GEN_ID_LSB +: 4];

	sgf_decide u_decide (
		.fwd     (fwd),
		.grp_cfg (st_reg.grp),
		.nsac_ok (st_reg.nsac),
		.ds      (st_reg.ctrl[SGF_CTRL_DS_BIT]),
		.sre_s   (st_reg.ctrl[SGF_CTRL_SRE_S_BIT]),
		.ar_both (st_reg.ctrl[SGF_CTRL_AR_S_BIT] && st_reg.ctrl[SGF_CTRL_AR_NS_BIT])
	);

	// one banked word per element stands for the system registers banked by security
	for (genvar p = 0; p < SGF_NPE; p++) begin : g_pe
		assign bank_wr[p] = wr_ok && hit_bank && (wb_pe_i == SGF_PE_W'(p));
		sgf_bank #(.W(32)) u_bank (
			.sys_clk (sys_clk),
			.rst_n   (rst_n),
			.wr      (bank_wr[p]),
			.secure  (wb_secure_i),
			.wdata   (wb_dat_i),
			.rdata   (bank_rd[p])
		);
	end

	function automatic logic [31:0] id_word(logic [15:0] o, logic [3:0] rev);
		if (o == SGF_ARCH_REV_OFS)
			return {24'h000000, rev, 4'h0};
		return SGF_IMPDEF_VALUE;
	endfunction

	always_comb begin
		logic [2*SGF_NPE-1:0] gmask;
		gmask = '0;
		st_next = st_reg;
		st_next.ack = req;
		st_next.err = 1'b0;
		st_next.fire = '0;
		st_next.g0 = '0;
		st_next.rdata = '0;
		if (req && !(hit_any && known)) begin
			st_next.ack = 1'b0;
			st_next.err = 1'b1;
		end
		if (fwd.valid) begin
			st_next.fire = fwd.signal;
			st_next.g0 = fwd.signal & fwd.as_group0;
			st_next.id = fwd.intid;
			st_next.last_fire = fwd.signal;
		end
		// control is secure only
		if (wr_ok && hit_ctrl && wb_secure_i)
			st_next.ctrl = wb_dat_i[3:0];
		if (wr_ok && hit_nsac && wb_secure_i)
			st_next.nsac = wb_dat_i[SGF_NPE-1:0];
		if (wr_ok && hit_grp) begin
			for (int i = 0; i < SGF_NPE; i++)
				if (wb_secure_i || st_reg.grp[2*i +: 2] == 2'(SGF_GRP_NS1) || st_reg.ctrl[SGF_CTRL_DS_BIT])
					gmask[2*i +: 2] = 2'b11;
			// nonsecure writes only land on nonsecure fields, or on every field while DS is set
			st_next.grp = (st_reg.grp & ~gmask) | (wb_dat_i[2*SGF_NPE-1:0] & gmask);
		end
		if (req && !wb_we_i) begin
			if (in_id)
				st_next.rdata = id_word(ofs, REV);
			else if (hit_ctrl && wb_secure_i)
				st_next.rdata = {28'h0000000, st_reg.ctrl};
			else if (hit_nsac && wb_secure_i)
				st_next.rdata = {{(32-SGF_NPE){1'b0}}, st_reg.nsac};
			else if (hit_grp) begin
				for (int i = 0; i < SGF_NPE; i++)
					if (wb_secure_i || st_reg.grp[2*i +: 2] == 2'(SGF_GRP_NS1) || st_reg.ctrl[SGF_CTRL_DS_BIT])
						gmask[2*i +: 2] = 2'b11;
				st_next.rdata = {{(32-2*SGF_NPE){1'b0}}, st_reg.grp & gmask};
			end else if (hit_bank)
				st_next.rdata = bank_rd[wb_pe_i];
			else if (hit_stat)
				st_next.rdata = {{(32-SGF_NPE){1'b0}}, st_reg.last_fire};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.ctrl <= SGF_CTRL_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wb_dat_o     = st_reg.rdata;
	assign wb_ack_o     = st_reg.ack;
	assign wb_err_o     = st_reg.err;
	assign swint_fire   = st_reg.fire;
	assign swint_group0 = st_reg.g0;
	assign swint_id     = st_reg.id;

	ns_s0_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fwd.valid && !fwd.secure && !st_reg.ctrl[SGF_CTRL_DS_BIT]
		|=> (swint_fire & swint_group0 & ~$past(st_reg.nsac)) == '0)
		else $error("nonsecure swint reached a blocked target");
	ack_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	fire_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!fwd.valid |=> swint_fire == '0)
		else $error("swint fired without a generate write");
	rev_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		req && !wb_we_i && known && ofs == SGF_ARCH_REV_OFS |=> wb_dat_o == {24'h000000, REV, 4'h0})
		else $error("revision register wrong");
	ctrl_ns_wi_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_ok && hit_ctrl && !wb_secure_i |=> st_reg.ctrl == $past(st_reg.ctrl))
		else $error("nonsecure write changed control");
	ctrl_ns_raz_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		req && !wb_we_i && hit_ctrl && !wb_secure_i |=> wb_dat_o == 32'h0000_0000)
		else $error("nonsecure read saw control");
	routing_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fwd.valid && !(st_reg.ctrl[SGF_CTRL_AR_S_BIT] && st_reg.ctrl[SGF_CTRL_AR_NS_BIT]) |=> swint_fire == '0)
		else $error("swint fired with routing off");
	s_alt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fwd.valid && fwd.secure && fwd.kind == SGF_GEN_ALT_G1 |=> swint_group0 == '0)
		else $error("secure alt write reached a secure group");
endmodule
